// [hdl/seqc_consts.svh]
// Purpose: Shared constants of the sequencer control front end.
// Assumes: Included by bare name; definitions only.
// Notes: Times in ns, counts derived from the pclk period.
`ifndef SEQC_CONSTS_SVH
`define SEQC_CONSTS_SVH
// Sequencer clock dividers
`define SEQC_DIV_14BIT 16'd48
`define SEQC_DIV_12BIT 16'd64
`define SEQC_DIV_INTERP 16'd24
// Runtime select port layout
`define SEQC_DATA_W 13
`define SEQC_IDX_W 19
`define SEQC_UP_LSB 13
`define SEQC_UP_W 6
// Index load latency in sequencer clock cycles
`define SEQC_LOAD_LAT 3'd7
// Clock period and least spacing between index updates
`define SEQC_CLK_NS 20
`define SEQC_UPD_MIN_NS 1000
`define SEQC_UPD_CYC ((`SEQC_UPD_MIN_NS + `SEQC_CLK_NS - 1) / `SEQC_CLK_NS)
// Controller register offsets
`define SEQC_OFF_CTRL 12'h000
`define SEQC_OFF_INDEX 12'h004
`define SEQC_OFF_STATUS 12'h008
// Controller control register fields
`define SEQC_CTRL_TRIG 0
`define SEQC_CTRL_EVT 1
`define SEQC_CTRL_M19 2
`define SEQC_CTRL_RST 32'h0000_0000
`endif

// [hdl/seqc_ctrl.sv]
// Purpose: External controller driving trigger, event and index lines.
// Assumes: APB slave with zero wait states.
// Notes: Index writes are refused while a transfer is in progress.
`include "seqc_consts.svh"

module seqc_ctrl #(
  parameter int LOAD_W = 4,
  parameter int GAP_CYC = `SEQC_UPD_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic busy,
  seqc_if.ctl link
);
  logic [31:0] ctrl_reg;
  logic [18:0] idx_reg;
  logic upper_reg;
  logic [7:0] cnt_reg;
  logic setup_ph, wr_acc, mapped;
  seqc_pkg::seqc_xfer_e st_reg;

  // APB decode
  assign setup_ph = psel & ~penable;
  assign wr_acc = psel & penable & pwrite;
  assign mapped = (paddr == `SEQC_OFF_CTRL) | (paddr == `SEQC_OFF_INDEX) |
                  (paddr == `SEQC_OFF_STATUS);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign busy = (st_reg != seqc_pkg::SEQC_IDLE);

  // Read data captured in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup_ph) begin
      unique case (paddr)
        `SEQC_OFF_CTRL: prdata <= ctrl_reg;
        `SEQC_OFF_INDEX: prdata <= {13'h0000, idx_reg};
        `SEQC_OFF_STATUS: prdata <= {31'h0000_0000, busy};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Control register drives trigger and event levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `SEQC_CTRL_RST;
    end else if (wr_acc && paddr == `SEQC_OFF_CTRL) begin
      ctrl_reg <= {29'h0000_0000, pwdata[2:0]};
    end
  end
  assign link.trig_pin = ctrl_reg[`SEQC_CTRL_TRIG];
  assign link.event_pin = ctrl_reg[`SEQC_CTRL_EVT];

  // Index transfer: upper half first in 19-bit mode, then lower
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= seqc_pkg::SEQC_IDLE;
      idx_reg <= 19'h00000;
      upper_reg <= 1'b0;
      cnt_reg <= 8'h00;
      link.dyn_data <= 13'h0000;
      link.dyn_hsel <= 1'b0;
      link.dyn_load <= 1'b0;
    end else begin
      unique case (st_reg)
        seqc_pkg::SEQC_IDLE: begin
          if (wr_acc && paddr == `SEQC_OFF_INDEX) begin
            idx_reg <= pwdata[18:0];
            upper_reg <= ctrl_reg[`SEQC_CTRL_M19];
            st_reg <= seqc_pkg::SEQC_SETUP;
          end
        end
        seqc_pkg::SEQC_SETUP: begin
          // Data and half-select settle one cycle before the strobe
          link.dyn_hsel <= upper_reg;
          link.dyn_data <= upper_reg ? {7'h00, idx_reg[18:13]}
                                     : idx_reg[12:0];
          cnt_reg <= 8'h00;
          st_reg <= seqc_pkg::SEQC_PULSE;
        end
        seqc_pkg::SEQC_PULSE: begin
          link.dyn_load <= 1'b1;
          cnt_reg <= cnt_reg + 8'h01;
          if (cnt_reg == 8'(LOAD_W - 1)) begin
            link.dyn_load <= 1'b0;
            cnt_reg <= 8'h00;
            st_reg <= seqc_pkg::SEQC_GAP;
          end
        end
        seqc_pkg::SEQC_GAP: begin
          cnt_reg <= cnt_reg + 8'h01;
          if (cnt_reg == 8'(GAP_CYC - 1)) begin
            if (upper_reg) begin
              upper_reg <= 1'b0;
              st_reg <= seqc_pkg::SEQC_SETUP;
            end else begin
              link.dyn_hsel <= 1'b0;
              st_reg <= seqc_pkg::SEQC_IDLE;
            end
          end
        end
        default: st_reg <= seqc_pkg::SEQC_IDLE;
      endcase
    end
  end
endmodule

// [hdl/seqc_device.sv]
// Purpose: Sequencer control inputs of the waveform generator.
// Assumes: Link lines and config inputs are synchronous to pclk.
// Notes: Sequencer clock is an enable tick derived from pclk.
//
// Chosen here: the APB register port and the placing of the registers.
`include "seqc_consts.svh"

module seqc_device #(
  parameter int INTERP_W = 8,
  parameter int GEN_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  seqc_if.dev link,
  input wire seqc_pkg::seqc_dac_e dac_mode,
  input wire logic [INTERP_W-1:0] interp_factor,
  input wire logic trig_pol_inv,
  input wire seqc_pkg::seqc_edge_e trig_edge,
  input wire logic evt_pol_inv,
  input wire seqc_pkg::seqc_edge_e evt_edge,
  input wire seqc_pkg::seqc_tmode_e trig_mode,
  input wire logic armed,
  input wire logic mode19,
  input wire seqc_pkg::seqc_src_e trig_src,
  input wire seqc_pkg::seqc_src_e enable_src,
  input wire seqc_pkg::seqc_src_e adv_src,
  input wire logic gen_en,
  input wire logic [GEN_W-1:0] gen_period,
  input wire logic sw_trigger,
  input wire logic sw_enable,
  input wire logic sw_event,
  input wire logic sw_run,
  input wire logic sw_stop,
  input wire logic sw_idx_wr,
  input wire logic [18:0] sw_idx,
  input wire logic hw_dyn_disable,
  input wire logic seq_done,
  input wire logic seg_end,
  input wire logic seg_cond,
  output logic sync_tick,
  output logic run_mode,
  output logic seq_running,
  output logic seq_start,
  output logic seq_stop,
  output logic hold_first,
  output logic adv_pending,
  output logic adv_fire,
  output logic gen_trig,
  output logic idx_valid,
  output logic [18:0] idx_out
);
  logic [15:0] div_reg, div_next, div_max;
  logic [1:0] in_reg, in_prev_reg;
  logic trig_act, evt_act, gen_act, trig_lvl;
  logic trig_fn, enable_fn, adv_fn;
  logic [GEN_W-1:0] gen_cnt_reg;
  logic load_prev_reg;
  logic [5:0] up_reg;
  logic [12:0] lo_reg;
  logic [2:0] lat_reg;
  logic lat_busy_reg;
  logic enable_seen_reg;
  seqc_pkg::seqc_run_e st_reg;

  function automatic logic edge_hit(input logic cur, input logic prev,
                                    input seqc_pkg::seqc_edge_e md);
    unique case (md)
      seqc_pkg::SEQC_RISE: edge_hit = cur & ~prev;
      seqc_pkg::SEQC_FALL: edge_hit = ~cur & prev;
      seqc_pkg::SEQC_BOTH: edge_hit = cur ^ prev;
      default: edge_hit = 1'b0;
    endcase
  endfunction

  // Divide ratio of the sequencer clock
  always_comb begin
    unique case (dac_mode)
      seqc_pkg::SEQC_DAC14: div_max = `SEQC_DIV_14BIT;
      seqc_pkg::SEQC_DAC12: div_max = `SEQC_DIV_12BIT;
      seqc_pkg::SEQC_INTERP: div_max = 16'(`SEQC_DIV_INTERP * interp_factor);
      default: div_max = `SEQC_DIV_14BIT;
    endcase
    div_next = (div_reg + 16'd1 >= div_max) ? 16'd0 : div_reg + 16'd1;
  end

  // Sequencer clock tick, one pclk cycle per sequencer period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= 16'd0;
    end else begin
      div_reg <= div_next;
    end
  end
  assign sync_tick = (div_reg == 16'd0);

  // Polarity applied, sampled on the tick; software ORed in
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_reg <= 2'h0;
      in_prev_reg <= 2'h0;
    end else if (sync_tick) begin
      in_reg <= {link.event_pin ^ evt_pol_inv,
                 link.trig_pin ^ trig_pol_inv};
      in_prev_reg <= in_reg;
    end
  end
  assign trig_lvl = in_reg[0] | sw_trigger;
  assign trig_act = sync_tick &
    (edge_hit(in_reg[0], in_prev_reg[0], trig_edge) | sw_trigger);
  assign evt_act = sync_tick &
    (edge_hit(in_reg[1], in_prev_reg[1], evt_edge) | sw_event);

  // Internal trigger generator counting sequencer ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gen_cnt_reg <= '0;
    end else if (!gen_en) begin
      gen_cnt_reg <= '0;
    end else if (sync_tick) begin
      gen_cnt_reg <= (gen_cnt_reg >= gen_period) ? '0 : gen_cnt_reg + 1'b1;
    end
  end
  assign gen_act = gen_en & sync_tick & (gen_cnt_reg == gen_period);
  assign gen_trig = gen_act;

  // Source routing of the logical functions
  always_comb begin
    unique case (trig_src)
      seqc_pkg::SEQC_SRC_GEN: trig_fn = gen_act;
      seqc_pkg::SEQC_SRC_EVT: trig_fn = evt_act;
      default: trig_fn = trig_act;
    endcase
    unique case (enable_src)
      seqc_pkg::SEQC_SRC_GEN: enable_fn = gen_act;
      seqc_pkg::SEQC_SRC_EVT: enable_fn = evt_act;
      default: enable_fn = trig_act;
    endcase
    enable_fn = enable_fn | (sync_tick & sw_enable);
    unique case (adv_src)
      seqc_pkg::SEQC_SRC_GEN: adv_fn = gen_act;
      seqc_pkg::SEQC_SRC_TRIG: adv_fn = trig_act;
      default: adv_fn = evt_act;
    endcase
  end

  // Stored advancement event; a new event wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adv_pending <= 1'b0;
    end else begin
      adv_pending <= adv_fn | (adv_pending & ~adv_fire);
    end
  end
  // Pending event is released at any segment end; seg_cond is not used
  assign adv_fire = adv_pending & seg_end;

  // Run control and start logic, evaluated on the sequencer tick; sw_stop acts in any cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= seqc_pkg::SEQC_PROG;
      seq_start <= 1'b0;
      seq_stop <= 1'b0;
      hold_first <= 1'b0;
      enable_seen_reg <= 1'b0;
    end else begin
      seq_start <= 1'b0;
      seq_stop <= 1'b0;
      if (enable_fn) begin
        enable_seen_reg <= 1'b1;
        hold_first <= 1'b0;
      end
      if (sw_stop) begin
        st_reg <= seqc_pkg::SEQC_PROG;
        seq_stop <= seq_running;
        hold_first <= 1'b0;
        enable_seen_reg <= 1'b0;
      end else if (sync_tick) begin
        unique case (st_reg)
          seqc_pkg::SEQC_PROG: begin
            if (sw_run) begin
              st_reg <= seqc_pkg::SEQC_WAIT;
              enable_seen_reg <= 1'b0;
            end
          end
          seqc_pkg::SEQC_WAIT: begin
            if (trig_mode == seqc_pkg::SEQC_CONT) begin
              st_reg <= seqc_pkg::SEQC_RUN;
              seq_start <= 1'b1;
              hold_first <= armed & ~enable_fn;
            end else if ((!armed || enable_seen_reg || enable_fn) &&
                ((trig_mode == seqc_pkg::SEQC_TRIGD && trig_fn) ||
                 (trig_mode == seqc_pkg::SEQC_GATED && trig_lvl))) begin
              st_reg <= seqc_pkg::SEQC_RUN;
              seq_start <= 1'b1;
            end
          end
          seqc_pkg::SEQC_RUN: begin
            // Triggers while running are dropped here
            if (trig_mode == seqc_pkg::SEQC_GATED && !trig_lvl) begin
              st_reg <= seqc_pkg::SEQC_WAIT;
              seq_stop <= 1'b1;
            end else if (seq_done) begin
              st_reg <= seqc_pkg::SEQC_WAIT;
            end
          end
          default: st_reg <= seqc_pkg::SEQC_PROG;
        endcase
      end
    end
  end
  assign run_mode = (st_reg != seqc_pkg::SEQC_PROG);
  assign seq_running = (st_reg == seqc_pkg::SEQC_RUN);

  // Runtime index capture on load rising edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_prev_reg <= 1'b0;
      up_reg <= 6'h00;
      lo_reg <= 13'h0000;
    end else begin
      load_prev_reg <= link.dyn_load;
      if (link.dyn_load && !load_prev_reg && !hw_dyn_disable) begin
        if (link.dyn_hsel) begin
          if (mode19) begin
            up_reg <= link.dyn_data[5:0];
          end
        end else begin
          lo_reg <= link.dyn_data;
        end
      end
    end
  end

  // Lower loads hand the index over after the load latency
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lat_reg <= 3'd0;
      lat_busy_reg <= 1'b0;
      idx_valid <= 1'b0;
      idx_out <= 19'h00000;
    end else begin
      idx_valid <= 1'b0;
      if (sw_idx_wr) begin
        idx_out <= sw_idx;
        idx_valid <= 1'b1;
        lat_busy_reg <= 1'b0;
      end else if (link.dyn_load && !load_prev_reg && !link.dyn_hsel &&
                   !hw_dyn_disable) begin
        lat_busy_reg <= 1'b1;
        lat_reg <= 3'd0;
      end else if (lat_busy_reg && sync_tick) begin
        if (lat_reg == `SEQC_LOAD_LAT - 3'd1) begin
          lat_busy_reg <= 1'b0;
          idx_out <= {mode19 ? up_reg : 6'h00, lo_reg};
          idx_valid <= 1'b1;
        end else begin
          lat_reg <= lat_reg + 3'd1;
        end
      end
    end
  end
endmodule

// [hdl/seqc_if.sv]
// Purpose: Link between the external controller and the device.
// Assumes: All lines are driven by the controller.
// Notes: Inputs of the device are synchronous to pclk.
interface seqc_if;
  logic trig_pin;
  logic event_pin;
  logic [12:0] dyn_data;
  logic dyn_hsel;
  logic dyn_load;
  modport dev (
    input trig_pin, event_pin, dyn_data, dyn_hsel, dyn_load
  );
  modport ctl (
    output trig_pin, event_pin, dyn_data, dyn_hsel, dyn_load
  );
endinterface

// [hdl/seqc_pkg.sv]
// Purpose: Types of the sequencer control front end.
// Assumes: Used as seqc_pkg::name, never imported.
// Notes: State enums are one-hot.
package seqc_pkg;
  typedef enum logic [1:0] {
    SEQC_DAC14 = 2'h0, SEQC_DAC12 = 2'h1, SEQC_INTERP = 2'h2
  } seqc_dac_e;
  typedef enum logic [1:0] {
    SEQC_CONT = 2'h0, SEQC_TRIGD = 2'h1, SEQC_GATED = 2'h2
  } seqc_tmode_e;
  typedef enum logic [1:0] {
    SEQC_RISE = 2'h0, SEQC_FALL = 2'h1, SEQC_BOTH = 2'h2
  } seqc_edge_e;
  typedef enum logic [1:0] {
    SEQC_SRC_TRIG = 2'h0, SEQC_SRC_GEN = 2'h1, SEQC_SRC_EVT = 2'h2
  } seqc_src_e;
  typedef enum logic [2:0] {
    SEQC_PROG = 3'h1, SEQC_WAIT = 3'h2, SEQC_RUN = 3'h4
  } seqc_run_e;
  typedef enum logic [3:0] {
    SEQC_IDLE = 4'h1, SEQC_SETUP = 4'h2, SEQC_PULSE = 4'h4, SEQC_GAP = 4'h8
  } seqc_xfer_e;
endpackage

// [tb/seqc_assertions.sv]
// Purpose: Concurrent checks on the link between controller and device and on the device outputs.
// Assumes: Instantiated beside the link interface in the bench top.
// Notes: Small counters stand in for long repetitions.
`include "seqc_consts.svh"
module seqc_assertions #(
  parameter int LOAD_W = 4,
  parameter int GAP_CYC = 5
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [12:0] dyn_data,
  input wire logic dyn_hsel,
  input wire logic dyn_load,
  input wire logic mode19,
  input wire logic hw_dyn_disable,
  input wire logic sw_idx_wr,
  input wire logic sync_tick,
  input wire logic idx_valid,
  input wire logic [18:0] idx_out,
  input wire logic seg_end,
  input wire logic adv_pending,
  input wire logic adv_fire,
  input wire logic seq_start,
  input wire logic seq_running
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ld_prev;
  logic ld_rise;
  logic lo_ld;
  logic hi_ld;
  logic [12:0] lo_q;
  logic [5:0] hi_q;
  logic [3:0] tk_cnt;
  logic [3:0] ld_cnt;
  logic [7:0] rr_cnt;
  // Loads as the device takes them
  assign ld_rise = dyn_load & ~ld_prev;
  assign lo_ld = ld_rise & ~hw_dyn_disable & ~dyn_hsel;
  assign hi_ld = ld_rise & ~hw_dyn_disable & dyn_hsel & mode19;
  // Expected index halves, strobe width, spacing and tick count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ld_prev <= 1'b0;
      lo_q <= 13'h0000;
      hi_q <= 6'h00;
      tk_cnt <= 4'hF;
      ld_cnt <= 4'h0;
      rr_cnt <= 8'hFF;
    end else begin
      ld_prev <= dyn_load;
      ld_cnt <= dyn_load ? ld_cnt + 4'h1 : 4'h0;
      rr_cnt <= ld_rise ? 8'h00 : rr_cnt + {7'h00, rr_cnt != 8'hFF};
      tk_cnt <= lo_ld ? 4'h0 : tk_cnt + {3'h0, sync_tick & (tk_cnt != 4'hF)};
      if (hi_ld) begin
        hi_q <= dyn_data[5:0];
      end
      if (lo_ld) begin
        lo_q <= dyn_data;
      end
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_load_width: assert property ($fell(dyn_load) |->
    ld_cnt == LOAD_W - 1) else $error("load strobe width wrong");
  a_load_stable: assert property (dyn_load && $past(dyn_load) |->
    $stable(dyn_data) && $stable(dyn_hsel)) else $error("load data moved");
  a_update_gap: assert property (ld_rise |-> rr_cnt >= GAP_CYC)
    else $error("index updates too close");
  a_upper_first: assert property (ld_rise && dyn_hsel |->
    ##[1:40] (ld_rise && !dyn_hsel)) else $error("no lower load");
  a_lower_only: assert property (ld_rise && !mode19 |-> !dyn_hsel)
    else $error("upper load in short mode");
  a_low_bits: assert property (idx_valid && !$past(sw_idx_wr) |->
    idx_out[12:0] == lo_q) else $error("lower index bits wrong");
  a_high_bits: assert property (idx_valid && !$past(sw_idx_wr) |->
    idx_out[18:13] == (mode19 ? hi_q : 6'h00)) else $error("upper bits");
  a_load_latency: assert property (idx_valid && !$past(sw_idx_wr) |->
    tk_cnt == `SEQC_LOAD_LAT) else $error("load latency wrong");
  a_load_handed: assert property (lo_ld |-> ##[1:460] idx_valid)
    else $error("lower load not handed on");
  a_adv_hold: assert property (adv_pending && !seg_end |=> adv_pending)
    else $error("event lost before use");
  a_adv_fire: assert property ($fell(adv_pending) |-> $past(adv_fire))
    else $error("pending event not applied");
  a_start_runs: assert property (seq_start |=> seq_running)
    else $error("start without running");
  c_lower_load: cover property (lo_ld);
  c_upper_load: cover property (hi_ld);
  c_adv_fire: cover property (adv_fire);
  c_start: cover property (seq_start);
endmodule

// [tb/tb_sequencer_control_inputs.sv]
// Purpose: Bench for the sequencer control front end, both ends joined.
// Assumes: Controller reached over APB; device settings driven directly.
// Notes: Update gap shortened to 5 cycles.
`include "seqc_consts.svh"
module tb_sequencer_control_inputs;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] interp_factor;
  logic [15:0] gen_period;
  logic [18:0] sw_idx, idx_out;
  logic trig_pol_inv, evt_pol_inv, armed, mode19, gen_en, sw_trigger;
  logic sw_enable, sw_event, sw_run, sw_stop, sw_idx_wr, hw_dyn_disable;
  logic seq_done, seg_end, seg_cond, sync_tick, run_mode, seq_running;
  logic seq_start, seq_stop, hold_first, adv_pending, adv_fire, gen_trig;
  logic idx_valid, er, got;
  seqc_pkg::seqc_dac_e dac_mode;
  seqc_pkg::seqc_edge_e trig_edge, evt_edge;
  seqc_pkg::seqc_tmode_e trig_mode;
  seqc_pkg::seqc_src_e trig_src, enable_src, adv_src;
  int num_errors = 0;
  int samples_checked = 0;
  int n;
  seqc_if link_i ();
  seqc_ctrl #(.LOAD_W(4), .GAP_CYC(5)) seqc_ctrl_i (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .busy(busy), .link(link_i));
  seqc_device seqc_device_i (.pclk(pclk), .presetn(presetn),
    .link(link_i), .dac_mode(dac_mode), .interp_factor(interp_factor),
    .trig_pol_inv(trig_pol_inv), .trig_edge(trig_edge),
    .evt_pol_inv(evt_pol_inv), .evt_edge(evt_edge), .trig_mode(trig_mode),
    .armed(armed), .mode19(mode19), .trig_src(trig_src),
    .enable_src(enable_src), .adv_src(adv_src), .gen_en(gen_en),
    .gen_period(gen_period), .sw_trigger(sw_trigger),
    .sw_enable(sw_enable), .sw_event(sw_event), .sw_run(sw_run),
    .sw_stop(sw_stop), .sw_idx_wr(sw_idx_wr), .sw_idx(sw_idx),
    .hw_dyn_disable(hw_dyn_disable), .seq_done(seq_done),
    .seg_end(seg_end), .seg_cond(seg_cond), .sync_tick(sync_tick),
    .run_mode(run_mode), .seq_running(seq_running),
    .seq_start(seq_start), .seq_stop(seq_stop), .hold_first(hold_first),
    .adv_pending(adv_pending), .adv_fire(adv_fire), .gen_trig(gen_trig),
    .idx_valid(idx_valid), .idx_out(idx_out));
  seqc_assertions #(.LOAD_W(4), .GAP_CYC(5)) chk_i (.pclk(pclk),
    .presetn(presetn), .dyn_data(link_i.dyn_data),
    .dyn_hsel(link_i.dyn_hsel), .dyn_load(link_i.dyn_load),
    .mode19(mode19), .hw_dyn_disable(hw_dyn_disable),
    .sw_idx_wr(sw_idx_wr), .sync_tick(sync_tick), .idx_valid(idx_valid),
    .idx_out(idx_out), .seg_end(seg_end), .adv_pending(adv_pending),
    .adv_fire(adv_fire), .seq_start(seq_start),
    .seq_running(seq_running));
  // Clock source
  always #10 pclk = ~pclk;
  // Comparison with counting
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Bounded wait for an output condition
  task automatic await(input int s, input int lim);
    got = 1'b0;
    for (int i = 0; i < lim && !got; i++) begin
      #1;
      case (s)
        0: got = (idx_valid === 1'b1);
        1: got = (seq_start === 1'b1);
        2: got = (seq_stop === 1'b1);
        3: got = (adv_pending === 1'b1);
        default: got = (hold_first === 1'b0);
      endcase
      if (!got) @(posedge pclk);
    end
  endtask
  // Cycles between two pulses of the tick or the generator
  task automatic meas(input logic g, output int c);
    c = 0;
    do @(posedge pclk); while ((g ? gen_trig : sync_tick) !== 1'b1);
    do begin
      @(posedge pclk);
      c++;
    end while ((g ? gen_trig : sync_tick) !== 1'b1);
  endtask
  // Index sent by the controller, checked at the device
  task automatic idx_case(input logic cm, input logic dm, input logic hd,
      input logic [18:0] v, input logic [18:0] e);
    @(posedge pclk);
    mode19 <= dm;
    hw_dyn_disable <= hd;
    apb(1'b1, `SEQC_OFF_CTRL, {29'h0, cm, 2'h0});
    apb(1'b1, `SEQC_OFF_INDEX, {13'h0, v});
    apb(1'b0, `SEQC_OFF_STATUS, 32'h0);
    chk(rd, 32'h1);
    await(0, 500);
    chk(32'(got), 32'(!hd));
    if (!hd) chk(32'(idx_out), 32'(e));
  endtask
  // Software stop back to programming mode
  task automatic stop_run();
    @(posedge pclk);
    sw_run <= 1'b0;
    sw_stop <= 1'b1;
    @(posedge pclk);
    sw_stop <= 1'b0;
    repeat (3) @(posedge pclk);
    #1 chk(32'(run_mode), 32'h0);
  endtask
  // Verdict and end of run
  task automatic summarize();
    $display("checked %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    #1_000_000;
    num_errors++;
    $display("[ERR] %0t timeout", $time);
    summarize();
  end
  // Main sequence
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, sw_idx} = '0;
    {trig_pol_inv, evt_pol_inv, armed, mode19, gen_en, sw_trigger} = '0;
    {sw_enable, sw_event, sw_run, sw_stop, sw_idx_wr, hw_dyn_disable} = '0;
    {seq_done, seg_end, seg_cond} = '0;
    interp_factor = 8'h03;
    gen_period = 16'h0003;
    dac_mode = seqc_pkg::SEQC_DAC14;
    trig_edge = seqc_pkg::SEQC_RISE;
    evt_edge = seqc_pkg::SEQC_RISE;
    trig_mode = seqc_pkg::SEQC_CONT;
    trig_src = seqc_pkg::SEQC_SRC_TRIG;
    enable_src = seqc_pkg::SEQC_SRC_TRIG;
    adv_src = seqc_pkg::SEQC_SRC_EVT;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    // Tick period in each converter mode
    for (int k = 0; k < 3; k++) begin
      @(posedge pclk);
      dac_mode <= seqc_pkg::seqc_dac_e'(k);
      meas(1'b0, n);
      meas(1'b0, n);
      chk(n, k == 0 ? `SEQC_DIV_14BIT : k == 1 ? `SEQC_DIV_12BIT :
        `SEQC_DIV_INTERP * 3);
    end
    @(posedge pclk);
    dac_mode <= seqc_pkg::SEQC_DAC14;
    // Index loads: both halves, kept upper, short mode, port off
    idx_case(1'b1, 1'b1, 1'b0, 19'h51234, 19'h51234);
    idx_case(1'b1, 1'b1, 1'b0, 19'h2ABCD, 19'h2ABCD);
    idx_case(1'b0, 1'b1, 1'b0, 19'h00FFF, 19'h2AFFF);
    idx_case(1'b0, 1'b0, 1'b0, 19'h71FFF, 19'h01FFF);
    idx_case(1'b1, 1'b1, 1'b1, 19'h12345, 19'h00000);
    @(posedge pclk);
    sw_idx <= 19'h60001;
    sw_idx_wr <= 1'b1;
    @(posedge pclk);
    sw_idx_wr <= 1'b0;
    await(0, 3);
    chk(32'(got), 32'h1);
    chk(32'(idx_out), 32'h60001);
    apb(1'b0, `SEQC_OFF_INDEX, 32'h0);
    chk(rd, 32'h12345);
    apb(1'b0, 12'hFFC, 32'h0);
    chk(32'(er), 32'h1);
    // Armed continuous run starts and holds the first segment until enable
    @(posedge pclk);
    armed <= 1'b1;
    sw_run <= 1'b1;
    repeat (150) @(posedge pclk);
    #1 chk(32'(run_mode), 32'h1);
    chk(32'(hold_first), 32'h1);
    @(posedge pclk);
    sw_enable <= 1'b1;
    await(4, 150);
    chk(32'(got), 32'h1);
    stop_run();
    // Triggered run, early trigger dropped, software trigger
    @(posedge pclk);
    {armed, sw_enable} <= 2'b00;
    trig_mode <= seqc_pkg::SEQC_TRIGD;
    sw_run <= 1'b1;
    repeat (150) @(posedge pclk);
    apb(1'b1, `SEQC_OFF_CTRL, 32'h1);
    await(1, 150);
    chk(32'(got), 32'h1);
    apb(1'b1, `SEQC_OFF_CTRL, 32'h0);
    repeat (100) @(posedge pclk);
    apb(1'b1, `SEQC_OFF_CTRL, 32'h1);
    await(1, 150);
    chk(32'(got), 32'h0);
    @(posedge pclk);
    seq_done <= 1'b1;
    repeat (60) @(posedge pclk);
    seq_done <= 1'b0;
    apb(1'b1, `SEQC_OFF_CTRL, 32'h0);
    repeat (100) @(posedge pclk);
    sw_trigger <= 1'b1;
    await(1, 150);
    chk(32'(got), 32'h1);
    // Gated: gate low stops, high starts, inverted polarity stops
    @(posedge pclk);
    sw_trigger <= 1'b0;
    trig_mode <= seqc_pkg::SEQC_GATED;
    await(2, 150);
    chk(32'(got), 32'h1);
    apb(1'b1, `SEQC_OFF_CTRL, 32'h1);
    await(1, 150);
    chk(32'(got), 32'h1);
    @(posedge pclk);
    trig_pol_inv <= 1'b1;
    await(2, 150);
    chk(32'(got), 32'h1);
    stop_run();
    // Internal trigger generator period
    @(posedge pclk);
    gen_en <= 1'b1;
    trig_src <= seqc_pkg::SEQC_SRC_GEN;
    meas(1'b1, n);
    meas(1'b1, n);
    chk(n, `SEQC_DIV_14BIT * 4);
    // Events: line rise, line fall with both edges, software event
    for (int k = 0; k < 3; k++) begin
      @(posedge pclk);
      if (k == 1) evt_edge <= seqc_pkg::SEQC_BOTH;
      if (k == 2) sw_event <= 1'b1;
      if (k < 2) apb(1'b1, `SEQC_OFF_CTRL, k == 0 ? 32'h2 : 32'h0);
      await(3, 150);
      chk(32'(got), 32'h1);
      @(posedge pclk);
      sw_event <= 1'b0;
      repeat (99) @(posedge pclk);
      #1 chk(32'(adv_pending), 32'h1);
      @(posedge pclk);
      seg_end <= 1'b1;
      seg_cond <= 1'b1;
      #1 chk(32'(adv_fire), 32'h1);
      @(posedge pclk);
      seg_end <= 1'b0;
      #1 chk(32'(adv_pending), 32'h0);
    end
    summarize();
  end
endmodule
